// ==== shared/sce_pkg.sv ====
// Constants for the host bus port and modem pin logic of the serial element.
// Assumes one 100 MHz clock; register selects are three bits wide.
package sce_pkg;

    // Register selects
    localparam logic [2:0] SCE_REG_DIV_LO = 3'h0;  // With divisor access bit set
    localparam logic [2:0] SCE_REG_DIV_HI = 3'h1;  // With divisor access bit set
    localparam logic [2:0] SCE_REG_IRQ_EN = 3'h1;
    localparam logic [2:0] SCE_REG_LINE   = 3'h3;
    localparam logic [2:0] SCE_REG_MCTRL  = 3'h4;
    localparam logic [2:0] SCE_REG_MSTAT  = 3'h6;

    // Interrupt enable fields
    localparam int SCE_IE_RX_DATA = 0;
    localparam int SCE_IE_TX_EMPTY = 1;
    localparam int SCE_IE_RX_ERR  = 2;
    localparam int SCE_IE_MODEM   = 3;

    // Line control field
    localparam int SCE_LC_DIV_ACC = 7;

    // Modem control fields
    localparam int SCE_MC_DTR  = 0;
    localparam int SCE_MC_RTS  = 1;
    localparam int SCE_MC_OUT2 = 3;
    localparam int SCE_MC_LOOP = 4;
    localparam int SCE_MC_AFE  = 5;

    // Modem status fields
    localparam int SCE_MS_D_CTS = 0;
    localparam int SCE_MS_D_DSR = 1;
    localparam int SCE_MS_D_DCD = 3;
    localparam int SCE_MS_CTS   = 4;
    localparam int SCE_MS_DSR   = 5;
    localparam int SCE_MS_DCD   = 7;

    // Reset values
    localparam logic [7:0]  SCE_RST_IRQ_EN = 8'h00;
    localparam logic [7:0]  SCE_RST_LINE   = 8'h00;
    localparam logic [7:0]  SCE_RST_MCTRL  = 8'h00;
    localparam logic [15:0] SCE_RST_DIV    = 16'h0001;
    localparam logic [7:0]  SCE_RST_DATA   = 8'h00;

endpackage : sce_pkg

// ==== src/sce_addr_latch.sv ====
// Address strobe latch: passes register and chip selects while the strobe is low
// and holds the last low-phase values while it is high. Inputs synchronous to clk_i.
`timescale 1ns/100ps
module sce_addr_latch
    import sce_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       strobe_n_i,
    input  wire logic [2:0] reg_sel_i,
    input  wire logic       chip_sel_i,
    output logic      [2:0] reg_sel_o,
    output logic            chip_sel_o
);

    logic [2:0] sel_ff;
    logic [2:0] nxt_sel;
    logic       cs_ff;
    logic       nxt_cs;

    always_comb
    begin
        nxt_sel = sel_ff;
        nxt_cs  = cs_ff;
        if (!strobe_n_i)
        begin
            nxt_sel = reg_sel_i;
            nxt_cs  = chip_sel_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sel_ff <= 3'h0;
            cs_ff  <= 1'b0;
        end
        else
        begin
            sel_ff <= nxt_sel;
            cs_ff  <= nxt_cs;
        end
    end

    // Transparent while low, frozen at the rising edge
    assign reg_sel_o  = strobe_n_i ? sel_ff : reg_sel_i;
    assign chip_sel_o = strobe_n_i ? cs_ff : chip_sel_i;

endmodule : sce_addr_latch

// ==== src/sce_baud_gen.sv ====
// Baud clock generator: divides clk_i by a 16-bit divisor into a registered
// clock output. A divisor of zero stops the output low.
`timescale 1ns/100ps
module sce_baud_gen
    import sce_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [15:0] divisor_i,
    output logic             baud_o
);

    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic        baud_ff;
    logic        nxt_baud;

    always_comb
    begin
        nxt_cnt  = cnt_ff;
        nxt_baud = 1'b0;
        if (divisor_i != 16'h0000)
        begin
            if (cnt_ff == 16'h0000 || cnt_ff >= divisor_i)
                nxt_cnt = divisor_i - 16'h0001;
            else
                nxt_cnt = cnt_ff - 16'h0001;
            // High for the upper half of each period
            nxt_baud = (nxt_cnt >= {1'b0, divisor_i[15:1]});
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_ff  <= 16'h0000;
            baud_ff <= 1'b0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            baud_ff <= nxt_baud;
        end
    end

    assign baud_o = baud_ff;

endmodule : sce_baud_gen

// ==== src/sce_host_port.sv ====
// Host bus port and modem pin logic of the asynchronous serial element.
// Assumes all pins are synchronous to clk_i; serial framing and FIFOs lie outside.
// Behaviour
// - The three register-select inputs choose the register on every read and write.
// - Selects pass through while strobe is low and hold from its rising edge.
// - Transmit 16x baud clock equals reference clock divided by the divisor.
// - Selected only with both high selects high and low select low.
// - Status bit 4 shows clear-to-send; bit 0 flags a change since read.
// - Clear-to-send change interrupts only with modem interrupts on and auto mode off.
// - In auto clear-to-send mode the input gates the next character start.
// - Status bit 7 shows carrier detect; bit 3 flags change; may interrupt.
// - Status bit 5 shows data-set-ready; bit 1 flags change; may interrupt.
// - Transceiver disable is high whenever the host is not reading.
// - Data-terminal-ready drives low when its control bit is set.
// - Data-terminal-ready goes inactive on master reset, loopback or cleared bit.
// - Interrupt output goes high when any enabled condition is pending.
// - Interrupt output drops once serviced or on master reset.
// - Active-high master reset clears all registers but the divisor and forces outputs other than the baud clock and receive tick to reset levels.
// - Eight-bit bidirectional data bus with output enable toward the host.
// - Read happens while selected and either read strobe is active.
// - Receiver is timed from a separate 16x receive clock input.
`timescale 1ns/100ps
module sce_host_port
    import sce_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       master_rst_i,
    input  wire logic [2:0] reg_sel_i,
    input  wire logic       addr_latch_strobe_n_i,
    input  wire logic       sel_hi_a_i,
    input  wire logic       sel_hi_b_i,
    input  wire logic       sel_lo_n_i,
    input  wire logic       read_strobe_n_i,
    input  wire logic       read_strobe_p_i,
    input  wire logic       write_strobe_n_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_o,
    output logic            xcvr_disable_o,
    output logic            irq_out_o,
    input  wire logic       cts_n_i,
    input  wire logic       dsr_n_i,
    input  wire logic       dcd_n_i,
    output logic            dtr_n_o,
    output logic            tx_baud16_clk_out_o,
    input  wire logic       rx_clk16_i,
    output logic            rx_tick_o,
    input  wire logic       rx_err_i,
    input  wire logic       rx_avail_i,
    input  wire logic       rx_timeout_i,
    input  wire logic       fifo_mode_i,
    input  wire logic       tx_empty_i,
    output logic            tx_start_ok_o
);

    logic [2:0]  sel_reg;
    logic        sel_cs;
    logic        chip_sel;
    logic        rd_act;
    logic        wr_act;
    logic        rd_start;
    logic        wr_start;
    logic [2:0]  modem_lvl;
    logic [2:0]  modem_chg;
    logic        modem_pend;
    logic        irq_pend;
    logic [7:0]  rd_data;

    logic        rd_prev_ff;
    logic        wr_prev_ff;
    logic [7:0]  ier_ff;
    logic [7:0]  lcr_ff;
    logic [7:0]  mcr_ff;
    logic [15:0] div_ff;
    logic [2:0]  lvl_ff;
    logic [2:0]  delta_ff;
    logic [7:0]  dout_ff;
    logic        doe_ff;
    logic        xdis_ff;
    logic        irq_ff;
    logic        dtr_n_ff;
    logic        txok_ff;
    logic        rxc_prev_ff;
    logic        rxtick_ff;

    logic [7:0]  nxt_ier;
    logic [7:0]  nxt_lcr;
    logic [7:0]  nxt_mcr;
    logic [15:0] nxt_div;
    logic [2:0]  nxt_delta;
    logic [7:0]  nxt_dout;
    logic        nxt_doe;
    logic        nxt_xdis;
    logic        nxt_irq;
    logic        nxt_dtr_n;
    logic        nxt_txok;
    logic        nxt_rxtick;

    assign chip_sel = sel_hi_a_i & sel_hi_b_i & ~sel_lo_n_i;

    sce_addr_latch u_addr_latch (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .strobe_n_i (addr_latch_strobe_n_i),
        .reg_sel_i  (reg_sel_i),
        .chip_sel_i (chip_sel),
        .reg_sel_o  (sel_reg),
        .chip_sel_o (sel_cs)
    );

    sce_baud_gen u_baud_gen (
        .clk_i     (clk_i),
        .rstn_i    (rstn_i),
        .divisor_i (div_ff),
        .baud_o    (tx_baud16_clk_out_o)
    );

    assign rd_act   = sel_cs & (~read_strobe_n_i | read_strobe_p_i);
    assign wr_act   = sel_cs & ~write_strobe_n_i;
    assign rd_start = rd_act & ~rd_prev_ff;
    assign wr_start = wr_act & ~wr_prev_ff;

    // Modem levels, true when active; loopback feeds them from modem control
    always_comb
    begin
        modem_lvl = {~dcd_n_i, ~dsr_n_i, ~cts_n_i};
        if (mcr_ff[SCE_MC_LOOP])
            modem_lvl = {mcr_ff[SCE_MC_OUT2], mcr_ff[SCE_MC_DTR], mcr_ff[SCE_MC_RTS]};
    end

    assign modem_chg = modem_lvl ^ lvl_ff;

    // Register read mux
    always_comb
    begin
        rd_data = 8'h00;
        unique case (sel_reg)
            SCE_REG_DIV_LO:
                rd_data = lcr_ff[SCE_LC_DIV_ACC] ? div_ff[7:0] : 8'h00;
            SCE_REG_IRQ_EN:
                rd_data = lcr_ff[SCE_LC_DIV_ACC] ? div_ff[15:8] : ier_ff;
            SCE_REG_LINE:
                rd_data = lcr_ff;
            SCE_REG_MCTRL:
                rd_data = mcr_ff;
            SCE_REG_MSTAT:
            begin
                rd_data[SCE_MS_CTS]   = lvl_ff[0];
                rd_data[SCE_MS_DSR]   = lvl_ff[1];
                rd_data[SCE_MS_DCD]   = lvl_ff[2];
                rd_data[SCE_MS_D_CTS] = delta_ff[0];
                rd_data[SCE_MS_D_DSR] = delta_ff[1];
                rd_data[SCE_MS_D_DCD] = delta_ff[2];
            end
            default:
                rd_data = 8'h00;
        endcase
    end

    // Modem interrupt: clear-to-send change counts only outside auto mode
    assign modem_pend = ier_ff[SCE_IE_MODEM]
                      & ((delta_ff[0] & ~mcr_ff[SCE_MC_AFE]) | delta_ff[1] | delta_ff[2]);

    assign irq_pend = (ier_ff[SCE_IE_RX_ERR] & rx_err_i)
                    | (ier_ff[SCE_IE_RX_DATA] & (rx_avail_i | (fifo_mode_i & rx_timeout_i)))
                    | (ier_ff[SCE_IE_TX_EMPTY] & tx_empty_i)
                    | modem_pend;

    // Next state of registers and outputs
    always_comb
    begin
        nxt_ier    = ier_ff;
        nxt_lcr    = lcr_ff;
        nxt_mcr    = mcr_ff;
        nxt_div    = div_ff;
        nxt_delta  = delta_ff;
        nxt_dout   = dout_ff;
        if (wr_start)
        begin
            unique case (sel_reg)
                SCE_REG_DIV_LO:
                    if (lcr_ff[SCE_LC_DIV_ACC])
                        nxt_div[7:0] = data_i;
                SCE_REG_IRQ_EN:
                    if (lcr_ff[SCE_LC_DIV_ACC])
                        nxt_div[15:8] = data_i;
                    else
                        nxt_ier = {4'h0, data_i[3:0]};
                SCE_REG_LINE:
                    nxt_lcr = data_i;
                SCE_REG_MCTRL:
                    nxt_mcr = {2'h0, data_i[5:0]};
                default:
                    nxt_ier = ier_ff;
            endcase
        end
        if (rd_start)
        begin
            nxt_dout = rd_data;
            if (sel_reg == SCE_REG_MSTAT)
                nxt_delta = 3'h0;
        end
        // A change in the reading cycle still sets its flag
        nxt_delta  = nxt_delta | modem_chg;
        nxt_doe    = rd_act;
        nxt_xdis   = ~rd_act;
        nxt_irq    = irq_pend;
        nxt_dtr_n  = ~(nxt_mcr[SCE_MC_DTR] & ~nxt_mcr[SCE_MC_LOOP]);
        nxt_txok   = ~mcr_ff[SCE_MC_AFE] | lvl_ff[0];
        nxt_rxtick = rx_clk16_i & ~rxc_prev_ff;
        if (master_rst_i)
        begin
            nxt_ier   = SCE_RST_IRQ_EN;
            nxt_lcr   = SCE_RST_LINE;
            nxt_mcr   = SCE_RST_MCTRL;
            nxt_delta = 3'h0;
            nxt_dout  = SCE_RST_DATA;
            nxt_doe   = 1'b0;
            nxt_xdis  = 1'b1;
            nxt_irq   = 1'b0;
            nxt_dtr_n = 1'b1;
            nxt_txok  = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rd_prev_ff  <= 1'b0;
            wr_prev_ff  <= 1'b0;
            ier_ff      <= SCE_RST_IRQ_EN;
            lcr_ff      <= SCE_RST_LINE;
            mcr_ff      <= SCE_RST_MCTRL;
            div_ff      <= SCE_RST_DIV;
            lvl_ff      <= 3'h0;
            delta_ff    <= 3'h0;
            dout_ff     <= SCE_RST_DATA;
            doe_ff      <= 1'b0;
            xdis_ff     <= 1'b1;
            irq_ff      <= 1'b0;
            dtr_n_ff    <= 1'b1;
            txok_ff     <= 1'b1;
            rxc_prev_ff <= 1'b0;
            rxtick_ff   <= 1'b0;
        end
        else
        begin
            rd_prev_ff  <= rd_act;
            wr_prev_ff  <= wr_act;
            ier_ff      <= nxt_ier;
            lcr_ff      <= nxt_lcr;
            mcr_ff      <= nxt_mcr;
            div_ff      <= nxt_div;
            lvl_ff      <= modem_lvl;
            delta_ff    <= nxt_delta;
            dout_ff     <= nxt_dout;
            doe_ff      <= nxt_doe;
            xdis_ff     <= nxt_xdis;
            irq_ff      <= nxt_irq;
            dtr_n_ff    <= nxt_dtr_n;
            txok_ff     <= nxt_txok;
            rxc_prev_ff <= rx_clk16_i;
            rxtick_ff   <= nxt_rxtick;
        end
    end

    assign data_o         = dout_ff;
    assign data_oe_o      = doe_ff;
    assign xcvr_disable_o = xdis_ff;
    assign irq_out_o      = irq_ff;
    assign dtr_n_o        = dtr_n_ff;
    assign tx_start_ok_o  = txok_ff;
    assign rx_tick_o      = rxtick_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_chip_sel_gate: assert property (!sel_cs |=> !data_oe_o)
        else $error("data bus driven while not selected");
    a_xcvr_dis_read: assert property (!master_rst_i |=> (xcvr_disable_o == !$past(rd_act)))
        else $error("transceiver disable does not follow read");
    a_oe_during_read: assert property (rd_act && !master_rst_i |=> data_oe_o)
        else $error("data bus not driven during read");
    a_cts_delta_set: assert property (modem_chg[0] && !master_rst_i |=> delta_ff[0])
        else $error("clear-to-send change not flagged");
    a_dsr_delta_set: assert property (modem_chg[1] && !master_rst_i |=> delta_ff[1])
        else $error("data-set-ready change not flagged");
    a_dcd_delta_set: assert property (modem_chg[2] && !master_rst_i |=> delta_ff[2])
        else $error("carrier detect change not flagged");
    a_auto_cts_mask: assert property (mcr_ff[SCE_MC_AFE] && delta_ff[0] && !delta_ff[1]
                                      && !delta_ff[2] && !rx_err_i && !rx_avail_i
                                      && !rx_timeout_i && !tx_empty_i |=> !irq_out_o)
        else $error("clear-to-send change interrupts in auto mode");
    a_irq_follows: assert property (!master_rst_i |=> irq_out_o == $past(irq_pend))
        else $error("interrupt output does not follow pending conditions");
    a_mrst_clears: assert property (master_rst_i |=> !irq_out_o && dtr_n_o && xcvr_disable_o)
        else $error("master reset did not force output levels");
    a_dtr_loop_off: assert property (mcr_ff[SCE_MC_LOOP] && !master_rst_i
                                     && !wr_start |=> dtr_n_o)
        else $error("data-terminal-ready active in loopback");
    a_txok_auto: assert property (mcr_ff[SCE_MC_AFE] && !lvl_ff[0] && !master_rst_i
                                  |=> !tx_start_ok_o)
        else $error("transmit start allowed without clear-to-send");

endmodule : sce_host_port

// ==== tb/sce_host_model.sv ====
// Host processor model: drives the parallel register bus of the serial element.
// Assumes the bench calls its tasks from one process and that clk_i is free running.
`timescale 1ns/100ps
module sce_host_model (
    input  wire logic       clk_i,
    output logic      [2:0] reg_sel_o,
    output logic            strobe_n_o,
    output logic      [2:0] cs_o,
    output logic            rd_n_o,
    output logic            rd_p_o,
    output logic            wr_n_o,
    output logic      [7:0] data_o
);
    logic [7:0] exp_q[$];

    initial
    begin
        reg_sel_o = 3'h0;
        strobe_n_o = 1'b0;
        cs_o = 3'h1;
        rd_n_o = 1'b1;
        rd_p_o = 1'b0;
        wr_n_o = 1'b1;
        data_o = 8'h00;
    end

    // Kind 0 writes, 1 reads on the low strobe, 2 reads on the high strobe
    task automatic cyc(input logic [2:0] a, input logic [2:0] cs, input int k,
                       input logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_sel_o = a;
        cs_o = cs;
        data_o = d;
        wr_n_o = (k != 0);
        rd_n_o = (k != 1);
        rd_p_o = (k == 2);
        repeat (2) @(posedge clk_i);
        #1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        rd_p_o = 1'b0;
        cs_o = 3'h1;
        data_o = ~d;        // Released bus shows no stale value
        @(posedge clk_i);
        #1;
    endtask : cyc

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        cyc(a, 3'h6, 0, d);
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [2:0] cs, input int k,
                      input logic [7:0] e);
        exp_q.push_back(e);
        cyc(a, cs, k, ~e);
    endtask : rd

    // Latches select a, then shows other selects behind a high strobe
    task automatic hold(input logic [2:0] a);
        @(posedge clk_i);
        #1;
        reg_sel_o = a;
        cs_o = 3'h6;
        strobe_n_o = 1'b0;
        @(posedge clk_i);
        #1;
        strobe_n_o = 1'b1;
        reg_sel_o = ~a;
        cs_o = 3'h1;
    endtask : hold
endmodule : sce_host_model

// ==== tb/sce_host_port_tb_top.sv ====
// Self-checking bench for the host bus port and modem pins of the serial element.
// Assumes the package and the host model are compiled first; clk_i runs at 100 MHz.
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sce_host_port_tb_top
    import sce_pkg::*;
;
    logic        clk_i, rstn_i, mrst, fifo_mode, rx_clk, strb_n, rd_n, rd_p, wr_n;
    logic [2:0]  mdm_n, reg_sel, cs;
    logic [3:0]  src;
    logic [7:0]  wdata, rdata, exp_v, lv, dl;
    logic        oe, xdis, irq, dtr_n, baud, tick, tx_ok, oe_q, bq;
    logic [15:0] since, per, dv;
    logic [31:0] rnd;
    int          bad_count, total_checks, ticks;
    int          lvb[3] = '{SCE_MS_CTS, SCE_MS_DSR, SCE_MS_DCD};
    int          dlb[3] = '{SCE_MS_D_CTS, SCE_MS_D_DSR, SCE_MS_D_DCD};
    int          ieb[4] = '{SCE_IE_RX_ERR, SCE_IE_RX_DATA, SCE_IE_TX_EMPTY, SCE_IE_RX_DATA};

    sce_host_model u_sce_host_model (.clk_i(clk_i), .reg_sel_o(reg_sel), .strobe_n_o(strb_n),
        .cs_o(cs), .rd_n_o(rd_n), .rd_p_o(rd_p), .wr_n_o(wr_n), .data_o(wdata));

    sce_host_port u_sce_host_port (.clk_i(clk_i), .rstn_i(rstn_i), .master_rst_i(mrst),
        .reg_sel_i(reg_sel), .addr_latch_strobe_n_i(strb_n), .sel_hi_a_i(cs[2]),
        .sel_hi_b_i(cs[1]), .sel_lo_n_i(cs[0]), .read_strobe_n_i(rd_n),
        .read_strobe_p_i(rd_p), .write_strobe_n_i(wr_n), .data_i(wdata), .data_o(rdata),
        .data_oe_o(oe), .xcvr_disable_o(xdis), .irq_out_o(irq), .cts_n_i(mdm_n[0]),
        .dsr_n_i(mdm_n[1]), .dcd_n_i(mdm_n[2]), .dtr_n_o(dtr_n), .tx_baud16_clk_out_o(baud),
        .rx_clk16_i(rx_clk), .rx_tick_o(tick), .rx_err_i(src[0]), .rx_avail_i(src[1]),
        .rx_timeout_i(src[3]), .fifo_mode_i(fifo_mode), .tx_empty_i(src[2]),
        .tx_start_ok_o(tx_ok));

    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : step

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wt

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Result watcher: pairs each read answer with the oldest note
    always @(posedge clk_i)
    begin
        #2;
        if (rstn_i === 1'b1)
        begin
            if (oe === 1'b1 && oe_q !== 1'b1)
            begin
                if (u_sce_host_model.exp_q.size() == 0)
                    `CHK(oe, 1'b0)
                else
                begin
                    exp_v = u_sce_host_model.exp_q.pop_front();
                    `CHK(rdata, exp_v)
                end
                `CHK(xdis, 1'b0)
            end
            if (oe === 1'b0)
                `CHK(xdis, 1'b1)
            if (tick === 1'b1)
                ticks++;
            if (baud === 1'b1 && bq !== 1'b1)
            begin
                per = since;
                since = 16'h1;
            end
            else
                since++;
        end
        oe_q = oe;
        bq = baud;
    end

    initial
    begin
        #100000;
        bad_count++;
        stop_test();
    end

    initial
    begin
        rstn_i = 1'b0;
        {mrst, rx_clk, fifo_mode, mdm_n, src} = {3'h1, 3'h7, 4'h0};
        {bad_count, total_checks, ticks, since, per} = '0;
        rnd = 32'h7469FE63;
        wt(8);
        rstn_i = 1'b1;
        wt(2);
        `CHK({dtr_n, irq, tx_ok}, 3'h5)
        for (int k = 0; k < 2; k++)
        begin
            rnd = step(rnd);
            u_sce_host_model.wr(SCE_REG_LINE, {1'b0, rnd[6:0]});
            u_sce_host_model.rd(SCE_REG_LINE, 3'h6, 2, {1'b0, rnd[6:0]});
            u_sce_host_model.wr(SCE_REG_IRQ_EN, rnd[15:8]);
            u_sce_host_model.rd(SCE_REG_IRQ_EN, 3'h6, 1, {4'h0, rnd[11:8]});
            u_sce_host_model.rd(3'h2, 3'h6, 1, 8'h00);
            dv = {13'h0, rnd[18:16]} + 16'h2;
            u_sce_host_model.wr(SCE_REG_LINE, 8'h80);
            u_sce_host_model.wr(SCE_REG_DIV_LO, dv[7:0]);
            u_sce_host_model.wr(SCE_REG_DIV_HI, 8'h00);
            u_sce_host_model.wr(SCE_REG_LINE, 8'h00);
            wt(30);
            `CHK(per, dv)
        end
        u_sce_host_model.wr(SCE_REG_IRQ_EN, 8'h08);
        for (int i = 0; i < 3; i++)
        begin
            lv = 8'h1 << lvb[i];
            dl = 8'h1 << dlb[i];
            mdm_n[i] = 1'b0;
            wt(4);
            `CHK(irq, 1'b1)
            u_sce_host_model.rd(SCE_REG_MSTAT, 3'h6, 1, lv | dl);
            wt(2);
            `CHK(irq, 1'b0)
            u_sce_host_model.rd(SCE_REG_MSTAT, 3'h6, 1, lv);
            mdm_n[i] = 1'b1;
            wt(4);
            `CHK(irq, 1'b1)
            u_sce_host_model.rd(SCE_REG_MSTAT, 3'h6, 2, dl);
        end
        u_sce_host_model.wr(SCE_REG_MCTRL, 8'h20);
        mdm_n[0] = 1'b0;
        wt(4);
        `CHK({irq, tx_ok}, 2'h1)
        mdm_n[0] = 1'b1;
        wt(4);
        `CHK({irq, tx_ok}, 2'h0)
        u_sce_host_model.rd(SCE_REG_MSTAT, 3'h6, 1, 8'h01);
        u_sce_host_model.wr(SCE_REG_MCTRL, 8'h00);
        mdm_n[2] = 1'b0;
        wt(3);
        u_sce_host_model.hold(SCE_REG_MSTAT);
        u_sce_host_model.rd(3'h1, 3'h1, 1, 8'h88);
        u_sce_host_model.strobe_n_o = 1'b0;
        mdm_n[2] = 1'b1;
        wt(3);
        u_sce_host_model.rd(SCE_REG_MSTAT, 3'h6, 1, 8'h08);
        `CHK(tx_ok, 1'b1)
        fifo_mode = 1'b1;
        for (int j = 0; j < 4; j++)
        begin
            u_sce_host_model.wr(SCE_REG_IRQ_EN, 8'h0F ^ (8'h1 << ieb[j]));
            src[j] = 1'b1;
            wt(3);
            `CHK(irq, 1'b0)
            u_sce_host_model.wr(SCE_REG_IRQ_EN, 8'h1 << ieb[j]);
            wt(3);
            `CHK(irq, 1'b1)
            src[j] = 1'b0;
            wt(3);
            `CHK(irq, 1'b0)
        end
        fifo_mode = 1'b0;
        src[3] = 1'b1;
        wt(3);
        `CHK(irq, 1'b0)
        src = 4'h2;
        u_sce_host_model.wr(SCE_REG_MCTRL, 8'h01);
        wt(2);
        `CHK(dtr_n, 1'b0)
        for (int c = 0; c < 8; c++)
        begin
            if (c != 6)
            begin
                u_sce_host_model.cyc(SCE_REG_MCTRL, c[2:0], 0, 8'h00);
                u_sce_host_model.cyc(SCE_REG_MSTAT, c[2:0], c % 2 + 1, 8'h00);
            end
        end
        `CHK({dtr_n, irq}, 2'h1)
        u_sce_host_model.wr(SCE_REG_MCTRL, 8'h11);
        wt(2);
        `CHK(dtr_n, 1'b1)
        u_sce_host_model.wr(SCE_REG_MCTRL, 8'h01);
        u_sce_host_model.wr(SCE_REG_IRQ_EN, 8'h0F);
        wt(3);
        `CHK({dtr_n, irq}, 2'h1)
        mrst = 1'b1;
        wt(1);
        mrst = 1'b0;
        wt(2);
        `CHK({dtr_n, irq, xdis}, 3'h5)
        u_sce_host_model.rd(SCE_REG_IRQ_EN, 3'h6, 1, 8'h00);
        src = 4'h0;
        ticks = 0;
        repeat (5)
        begin
            rx_clk = 1'b1;
            wt(3);
            rx_clk = 1'b0;
            wt(3);
        end
        `CHK(ticks, 5)
        wt(4);
        stop_test();
    end
endmodule : sce_host_port_tb_top
